//--- rtl/flash_host_pkg.sv
// Notes on behaviour
// - Chip select, write strobe and output drive are separate; never drive during reads.
// - Commands are plain write cycles into the device command register.
// - Completion shows on ready/busy pin or poll bits; host may use either.
// - Host may suspend erase indefinitely; device resumes on resume command.
`default_nettype none
package flash_host_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h4;
	localparam logic [3:0] REG_WDATA = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hC;
	localparam int CTRL_GO = 0;
	localparam int CTRL_WRITE = 1;
	localparam int CTRL_WORD = 2;
	localparam int CTRL_STBY = 3;
	localparam int CTRL_RST = 4;
	localparam int CTRL_WAITRDY = 5;
	localparam int ST_BUSY = 0;
	localparam int ST_RDY = 1;
	localparam int ST_RDATA = 16;
	localparam int SETUP_NS = 20;
	localparam int STROBE_NS = 60;
	localparam int HOLD_NS = 20;
	localparam int RST_NS = 500;
	localparam int CLK_NS = 4;
	localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int RST_CYC = (RST_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 8;
	localparam int ST_POLL_BIT = 7;
	localparam int ST_TOG_BIT = 6;
	typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_WAITRDY, S_RESET} phase_t;
	typedef struct packed {
		logic n_ce;
		logic n_we;
		logic n_oe;
		logic n_rst;
		logic byte_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dout;
		logic dout_en;
	} flash_pins_t;
endpackage
`default_nettype wire

//--- rtl/flash_host.sv
// Chosen here: the Avalon-MM interface to the registers and the address map.
`default_nettype none
module flash_host (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic [flash_host_pkg::DATA_W-1:0] i_data_lines,
	input wire logic i_op_done_indicator,
	output flash_host_pkg::flash_pins_t o_pins
);
	import flash_host_pkg::*;
	// ****************
	// State
	// ****************
	typedef struct packed {
		phase_t ph;
		logic [CNT_W-1:0] cnt;
		logic wr;
		logic word;
		logic stby;
		logic waitrdy;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
		logic rdy_q;
		logic ack;
		logic [31:0] rd;
		flash_pins_t pins;
	} state_t;
	state_t s_q, s_d;
	logic busy;
	assign busy = (s_q.ph != S_IDLE);
	// ****************
	// Next state
	// ****************
	always_comb begin
		s_d = s_q;
		s_d.ack = 1'b0;
		s_d.rdy_q = i_op_done_indicator;
		if ((i_avs_read || i_avs_write) && !s_q.ack) begin
			s_d.ack = 1'b1;
			if (i_avs_read) begin
				unique case (i_avs_address)
					REG_CTRL: s_d.rd = {26'h0, s_q.waitrdy, 2'h0, s_q.stby, s_q.word, s_q.wr};
					REG_ADDR: s_d.rd = {12'h0, s_q.addr};
					REG_WDATA: s_d.rd = {16'h0, s_q.wdata};
					REG_STATUS: s_d.rd = {s_q.rdata, 14'h0, s_q.rdy_q, busy};
					default: s_d.rd = 32'h0;
				endcase
			end else if (!busy) begin
				unique case (i_avs_address)
					REG_CTRL: begin
						s_d.wr = i_avs_writedata[CTRL_WRITE];
						s_d.word = i_avs_writedata[CTRL_WORD];
						s_d.stby = i_avs_writedata[CTRL_STBY];
						s_d.waitrdy = i_avs_writedata[CTRL_WAITRDY];
						if (i_avs_writedata[CTRL_RST]) begin
							s_d.ph = S_RESET;
							s_d.cnt = '0;
						end else if (i_avs_writedata[CTRL_GO]) begin
							s_d.ph = S_SETUP;
							s_d.cnt = '0;
						end
					end
					REG_ADDR: s_d.addr = i_avs_writedata[ADDR_W-1:0];
					REG_WDATA: s_d.wdata = i_avs_writedata[DATA_W-1:0];
					default: ;
				endcase
			end
		end
		s_d.pins.n_rst = 1'b1;
		s_d.pins.n_ce = s_q.stby;
		s_d.pins.n_we = 1'b1;
		s_d.pins.n_oe = 1'b1;
		s_d.pins.dout_en = 1'b0;
		s_d.pins.byte_n = s_q.word;
		s_d.pins.addr = s_q.addr;
		s_d.pins.dout = s_q.word ? s_q.wdata : {{BYTE_W{1'b0}}, s_q.wdata[BYTE_W-1:0]};
		unique case (s_q.ph)
			S_IDLE: ;
			S_RESET: begin
				s_d.pins.n_rst = 1'b0;
				s_d.cnt = s_q.cnt + 1'b1;
				if (s_q.cnt == CNT_W'(RST_CYC - 1)) s_d.ph = S_IDLE;
			end
			S_SETUP: begin
				s_d.pins.n_ce = 1'b0;
				s_d.pins.dout_en = s_q.wr;
				s_d.cnt = s_q.cnt + 1'b1;
				if (s_q.cnt == CNT_W'(SETUP_CYC - 1)) begin
					s_d.ph = S_STROBE;
					s_d.cnt = '0;
				end
			end
			S_STROBE: begin
				s_d.pins.n_ce = 1'b0;
				s_d.pins.n_we = !s_q.wr;
				s_d.pins.n_oe = s_q.wr;
				s_d.pins.dout_en = s_q.wr;
				s_d.cnt = s_q.cnt + 1'b1;
				if (s_q.cnt == CNT_W'(STROBE_CYC - 1)) begin
					s_d.ph = S_HOLD;
					s_d.cnt = '0;
					if (!s_q.wr) s_d.rdata = s_q.word ? i_data_lines :
						{{BYTE_W{1'b0}}, i_data_lines[BYTE_W-1:0]};
				end
			end
			S_HOLD: begin
				s_d.pins.n_ce = 1'b0;
				s_d.pins.dout_en = s_q.wr;
				s_d.cnt = s_q.cnt + 1'b1;
				if (s_q.cnt == CNT_W'(HOLD_CYC - 1)) begin
					s_d.ph = (s_q.wr && s_q.waitrdy) ? S_WAITRDY : S_IDLE;
					s_d.cnt = '0;
				end
			end
			S_WAITRDY: begin
				s_d.cnt = s_q.cnt + 1'b1;
				if (s_q.cnt == CNT_W'(HOLD_CYC - 1)) s_d.cnt = s_q.cnt;
				if (s_q.cnt == CNT_W'(HOLD_CYC - 1) && s_q.rdy_q) s_d.ph = S_IDLE;
			end
			default: s_d.ph = S_IDLE;
		endcase
	end
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s_q <= '0;
			s_q.pins.n_ce <= 1'b1;
			s_q.pins.n_we <= 1'b1;
			s_q.pins.n_oe <= 1'b1;
			s_q.pins.n_rst <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end
	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !s_q.ack;
	assign o_avs_readdata = s_q.rd;
	assign o_pins = s_q.pins;
endmodule // flash_host
`default_nettype wire

//--- verif/flash_dev_model.sv
`default_nettype none
module flash_dev_model import flash_host_pkg::*; (
	input wire logic i_clk,
	input wire flash_pins_t i_pins,
	output logic [DATA_W-1:0] o_data,
	output logic o_rdy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DATA_W-1:0] mem [16];
	logic [DATA_W-1:0] last = 16'h0000;
	logic we_q = 1'b1;
	int busy = 0;
	wire logic rd = !i_pins.n_ce && !i_pins.n_oe && !i_pins.dout_en;
	initial foreach (mem[i]) mem[i] = 16'hFFFF;
	always @(posedge i_clk) begin
		we_q <= i_pins.n_we;
		if (!i_pins.n_rst) busy <= 0;
		else if (!we_q && i_pins.n_we && !i_pins.n_ce) begin
			mem[i_pins.addr[3:0]] <= mem[i_pins.addr[3:0]] & i_pins.dout;
			busy <= 20;
		end else if (busy > 0) busy <= busy - 1;
		if (rd) last <= o_data;
	end
	assign o_rdy = (busy == 0);
	assign o_data = rd ? mem[i_pins.addr[3:0]] : ~last;
endmodule // flash_dev_model
`default_nettype wire

//--- verif/flash_host_properties.sv
`default_nettype none
module flash_host_properties import flash_host_pkg::*; (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic o_avs_waitrequest,
	input wire flash_host_pkg::flash_pins_t o_pins
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_low15(logic s);
		!s [*8] ##1 !s [*7] ##1 s;
	endsequence
	property p_fight; o_pins.dout_en |-> o_pins.n_oe; endproperty
	a_fight: assert property (p_fight) else $error("drive in read");
	property p_wsel; !o_pins.n_we |-> !o_pins.n_ce && o_pins.dout_en; endproperty
	a_wsel: assert property (p_wsel) else $error("strobe unselected");
	property p_ack; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_wlen; $fell(o_pins.n_we) |-> s_low15(o_pins.n_we); endproperty
	a_wlen: assert property (p_wlen) else $error("strobe width");
	property p_olen; $fell(o_pins.n_oe) |-> s_low15(o_pins.n_oe); endproperty
	a_olen: assert property (p_olen) else $error("read width");
	property p_hold; !o_pins.n_we |-> $stable(o_pins.addr) && $stable(o_pins.dout); endproperty
	a_hold: assert property (p_hold) else $error("moved in strobe");
	property p_rlen; $fell(o_pins.n_rst) |-> !o_pins.n_rst [*8]; endproperty
	a_rlen: assert property (p_rlen) else $error("reset short");
	property p_rq; !o_pins.n_rst |-> o_pins.n_we && o_pins.n_oe; endproperty
	a_rq: assert property (p_rq) else $error("access in reset");
endmodule // flash_host_properties
bind flash_host flash_host_properties u_flash_host_properties (.i_ref_clk, .i_sys_rst,
	.i_avs_read, .i_avs_write, .o_avs_waitrequest, .o_pins);
`default_nettype wire

//--- verif/flash_host_bench.sv
`default_nettype none
module flash_host_bench import flash_host_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, rd = 0, wr = 0, wt, rdy, saw = 0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0, rdt, q, dv;
	logic [15:0] dl;
	logic [15:0] exp_mem [16];
	flash_pins_t pins;
	int seed = 56900, err_total = 0, checked = 0, a;
	always #2 clk = ~clk;
	flash_host u_flash_host (.i_ref_clk(clk), .i_sys_rst(rst), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdt),
		.o_avs_waitrequest(wt), .i_data_lines(dl), .i_op_done_indicator(rdy), .o_pins(pins));
	flash_dev_model u_flash_dev_model (.i_clk(clk), .i_pins(pins), .o_data(dl), .o_rdy(rdy));
	always @(posedge clk) if (!pins.n_rst) saw <= 1'b1;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (e !== s) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic bus(input logic [3:0] ad, input logic w, input logic [31:0] d);
		adr <= ad;
		rd <= !w;
		wr <= w;
		wd <= d;
		@(posedge clk);
		while (wt !== 1'b0) @(posedge clk);
		q = rdt;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic op(input logic [31:0] c);
		bus(REG_CTRL, 1'b1, c);
		do bus(REG_STATUS, 1'b0, 32'h0); while (q[ST_BUSY] !== 1'b0);
	endtask
	task automatic give_verdict;
		$display("Checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		foreach (exp_mem[i]) exp_mem[i] = 16'hFFFF;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 6; i++) begin
			a = $random(seed) & 15;
			dv = $random(seed);
			bus(REG_ADDR, 1'b1, 32'(a));
			bus(REG_WDATA, 1'b1, dv);
			op(32'h27);
			chk("ready", 32'h1, 32'(q[ST_RDY]));
			exp_mem[a] &= dv[15:0];
			op(32'h05);
			chk("data", 32'(exp_mem[a]), 32'(q[31:16]));
		end
		bus(4'h1, 1'b0, 32'h0);
		chk("unmapped", 32'h0, q);
		op(32'h10);
		chk("reset pulse", 32'h1, 32'(saw));
		give_verdict;
	end
	initial begin
		#100us;
		err_total++;
		give_verdict;
	end
endmodule // flash_host_bench
`default_nettype wire
